/* rtl/ieis_link_shift.sv */
// Serial command shifter on the test clock.
// Assumes tck, tms and tdi come from the programmer; reset from ref_clk.
`default_nettype none

module ieis_link_shift import ieis_pkg::*; (
  input wire logic tck,
  input wire logic reset,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic enter_tgl,
  output logic exit_tgl
);

  logic rst_meta_r;
  logic rst_sync_r;
  logic [IR_W-1:0] shift_r;
  logic [IR_W-1:0] shift_nxt;
  logic tms_d_r;
  logic tdo_r;
  logic tdo_nxt;
  logic enter_r;
  logic enter_nxt;
  logic exit_r;
  logic exit_nxt;

  // ----------------------------------------------------------------
  // Reset crossing: only holds while tck runs
  // ----------------------------------------------------------------
  always_ff @(posedge tck) begin
    rst_meta_r <= reset;
    rst_sync_r <= rst_meta_r;
  end

  // ----------------------------------------------------------------
  // Shift and decode
  // ----------------------------------------------------------------
  always_comb begin
    enter_nxt = enter_r;
    exit_nxt = exit_r;
    if (tms) begin
      shift_nxt = {tdi, shift_r[IR_W-1:1]};
    end else begin
      shift_nxt = SILICON_ID;
    end
    if (tms_d_r && !tms) begin
      if (shift_r == CMD_ENTER) begin
        enter_nxt = ~enter_r;
      end
      if (shift_r == CMD_EXIT) begin
        exit_nxt = ~exit_r;
      end
    end
    tdo_nxt = shift_nxt[0];
  end

  always_ff @(posedge tck) begin
    if (rst_sync_r) begin
      shift_r <= SILICON_ID;
      tms_d_r <= 1'b0;
      tdo_r <= 1'b0;
      enter_r <= 1'b0;
      exit_r <= 1'b0;
    end else begin
      shift_r <= shift_nxt;
      tms_d_r <= tms;
      tdo_r <= tdo_nxt;
      enter_r <= enter_nxt;
      exit_r <= exit_nxt;
    end
  end

  assign tdo = tdo_r;
  assign enter_tgl = enter_r;
  assign exit_tgl = exit_r;

endmodule : ieis_link_shift

`default_nettype wire

/* rtl/ieis_pkg.sv */
// Constants shared by the I/O enable and in-system programming sequencer.
// Assumes ref_clk at 40 MHz and an AXI4-Lite master with 32-bit data.
// Functional notes
// - Per-pin enable: global signal or tie-off
// - Small variant: two globals from pins
// - Large variant: six selectable global enables
// - Tied low: tri-stated, pin is input
// - Tied high: output driven continuously
// - Pin and macrocell feedback stay independent
// - During programming: tri-state, weak pull-up
// - Programming only over four-pin test port
// - Enter stage: smooth switch, 1 ms
// - Exit stage: smooth return, 1 ms
`default_nettype none

package ieis_pkg;

  localparam int NPIN = 8;
  localparam int NGLB = 6;
  localparam int AW = 5;
  localparam int PSEL_W = 3;
  localparam int GSRC_W = 5;
  localparam int CNT_W = 16;
  localparam int IR_W = 8;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [AW-1:0] A_CTRL = 5'h00;
  localparam logic [AW-1:0] A_PSEL = 5'h04;
  localparam logic [AW-1:0] A_GSRC = 5'h08;
  localparam logic [AW-1:0] A_STAT = 5'h0C;
  localparam int CTRL_LARGE = 0;
  localparam logic CTRL_RST = 1'h0;
  localparam logic [NPIN*PSEL_W-1:0] PSEL_RST = 24'h000000;
  localparam logic [NGLB*GSRC_W-1:0] GSRC_RST = 30'h00000000;
  localparam logic [1:0] RESP_OKAY = 2'h0;
  localparam logic [1:0] RESP_SLVERR = 2'h2;

  // ----------------------------------------------------------------
  // Field codes
  // ----------------------------------------------------------------
  localparam logic [2:0] SEL_LOW = 3'h0;
  localparam logic [2:0] SEL_HIGH = 3'h1;
  localparam logic [2:0] SEL_GLB0 = 3'h2;
  localparam logic [1:0] K_ENA = 2'h0;
  localparam logic [1:0] K_PIN = 2'h1;
  localparam logic [1:0] K_MC = 2'h2;
  localparam logic [1:0] K_OFF = 2'h3;

  // ----------------------------------------------------------------
  // Link commands and identifier
  // ----------------------------------------------------------------
  localparam logic [IR_W-1:0] CMD_ENTER = 8'hA5;
  localparam logic [IR_W-1:0] CMD_EXIT = 8'h5A;
  // Identifier value is arbitrary
  localparam logic [IR_W-1:0] SILICON_ID = 8'h3C;

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int SETTLE_US = 1000;
  localparam int CLK_NS = 25;
  localparam int SETTLE_CYC_DEF = (SETTLE_US * 1000 + CLK_NS - 1) / CLK_NS;

  typedef enum logic [1:0] {
    ST_USER = 2'b00,
    ST_ENTER = 2'b01,
    ST_ISP = 2'b10,
    ST_EXIT = 2'b11
  } ieis_state_e;

endpackage : ieis_pkg

`default_nettype wire

/* rtl/ieis_top.sv */
// I/O enable control and programming-mode sequencer.
// Assumes an AXI4-Lite master on ref_clk and a programmer driving tck.
`default_nettype none

module ieis_top import ieis_pkg::*; #(
  parameter int SETTLE_CYC = SETTLE_CYC_DEF
) (
  input wire logic ref_clk,
  input wire logic reset,
  input wire logic awvalid,
  output logic awready,
  input wire logic [AW-1:0] awaddr,
  input wire logic wvalid,
  output logic wready,
  input wire logic [31:0] wdata,
  input wire logic [3:0] wstrb,
  output logic bvalid,
  input wire logic bready,
  output logic [1:0] bresp,
  input wire logic arvalid,
  output logic arready,
  input wire logic [AW-1:0] araddr,
  output logic rvalid,
  input wire logic rready,
  output logic [31:0] rdata,
  output logic [1:0] rresp,
  input wire logic output_enable_pin_a_n,
  input wire logic output_enable_pin_b_n,
  input wire logic [NPIN-1:0] pin_in,
  input wire logic [NPIN-1:0] mc_out,
  input wire logic tck,
  input wire logic tms,
  input wire logic tdi,
  output logic tdo,
  output logic [NPIN-1:0] pin_out,
  output logic [NPIN-1:0] pin_oe,
  output logic [NPIN-1:0] pin_pullup,
  output logic [NPIN-1:0] pin_fb,
  output logic [NPIN-1:0] mc_fb,
  output logic isp_active
);

  logic [1:0] oe_meta_r;
  logic [1:0] oe_s_r;
  logic [NPIN-1:0] pin_meta_r;
  logic [NPIN-1:0] pin_s_r;
  logic [1:0] tg_meta_r;
  logic [1:0] tg_s_r;
  logic [1:0] tg_d_r;
  logic enter_tgl;
  logic exit_tgl;
  logic enter_ev;
  logic exit_ev;
  logic ctrl_r, ctrl_nxt;
  logic [NPIN*PSEL_W-1:0] psel_r, psel_nxt;
  logic [NGLB*GSRC_W-1:0] gsrc_r, gsrc_nxt;
  logic [NGLB-1:0] glob_r, glob_nxt;
  logic [NPIN-1:0] oe_user;
  logic [NPIN-1:0] pin_oe_r, pin_oe_nxt;
  logic [NPIN-1:0] pin_pull_r, pin_pull_nxt;
  logic [NPIN-1:0] pin_out_r;
  logic [NPIN-1:0] pin_fb_r;
  logic [NPIN-1:0] mc_fb_r;
  ieis_state_e state_r, state_nxt;
  logic [CNT_W-1:0] cnt_r, cnt_nxt;
  logic isp_busy;
  logic isp_r;
  logic aw_got_r, aw_got_nxt, w_got_r, w_got_nxt;
  logic [AW-1:0] awaddr_r, awaddr_nxt, wa;
  logic [31:0] wdata_r, wdata_nxt, wd, wv;
  logic [3:0] wstrb_r, wstrb_nxt, ws;
  logic awready_r, awready_nxt, wready_r, wready_nxt;
  logic bvalid_r, bvalid_nxt, arready_r, arready_nxt;
  logic rvalid_r, rvalid_nxt;
  logic [1:0] bresp_r, bresp_nxt, rresp_r, rresp_nxt;
  logic [31:0] rdata_r, rdata_nxt;

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  function automatic logic oe_pick(input logic [2:0] sel,
                                   input logic [NGLB-1:0] g);
    if (sel == SEL_LOW) begin
      oe_pick = 1'b0;
    end else if (sel == SEL_HIGH) begin
      oe_pick = 1'b1;
    end else begin
      oe_pick = g[3'(sel - SEL_GLB0)];
    end
  endfunction : oe_pick

  function automatic logic glob_src(input logic [GSRC_W-1:0] s,
                                    input logic [1:0] en,
                                    input logic [NPIN-1:0] p,
                                    input logic [NPIN-1:0] m);
    unique case (s[4:3])
      K_ENA: glob_src = en[s[1]] ^ s[0];
      K_PIN: glob_src = p[s[2:0]];
      K_MC: glob_src = m[s[2:0]];
      K_OFF: glob_src = 1'b0;
    endcase
  endfunction : glob_src

  function automatic logic [31:0] merge(input logic [31:0] o,
                                        input logic [31:0] d,
                                        input logic [3:0] s);
    for (int b = 0; b < 4; b++) begin
      merge[b*8 +: 8] = s[b] ? d[b*8 +: 8] : o[b*8 +: 8];
    end
  endfunction : merge

  // ----------------------------------------------------------------
  // Test-clock side and crossings
  // ----------------------------------------------------------------
  ieis_link_shift u_link (
    .tck(tck),
    .reset(reset),
    .tms(tms),
    .tdi(tdi),
    .tdo(tdo),
    .enter_tgl(enter_tgl),
    .exit_tgl(exit_tgl)
  );

  // Pins and toggles are asynchronous, so two flops before any use
  always_ff @(posedge ref_clk) begin
    oe_meta_r <= {output_enable_pin_b_n, output_enable_pin_a_n};
    oe_s_r <= oe_meta_r;
    pin_meta_r <= pin_in;
    pin_s_r <= pin_meta_r;
    tg_meta_r <= {exit_tgl, enter_tgl};
    tg_s_r <= tg_meta_r;
    tg_d_r <= tg_s_r;
  end

  assign enter_ev = tg_s_r[0] ^ tg_d_r[0];
  assign exit_ev = tg_s_r[1] ^ tg_d_r[1];
  assign isp_busy = (state_r != ST_USER);

  // ----------------------------------------------------------------
  // Global enables and pin control
  // ----------------------------------------------------------------
  always_comb begin
    glob_nxt = '0;
    if (!ctrl_r) begin
      glob_nxt[1:0] = ~oe_s_r;
    end else begin
      for (int g = 0; g < NGLB; g++) begin
        glob_nxt[g] = glob_src(gsrc_r[g*GSRC_W +: GSRC_W], ~oe_s_r,
                               pin_s_r, mc_out);
      end
    end
    for (int i = 0; i < NPIN; i++) begin
      oe_user[i] = oe_pick(psel_r[i*PSEL_W +: PSEL_W], glob_r);
    end
    // Config registers are kept untouched during programming
    pin_oe_nxt = isp_busy ? '0 : oe_user;
    pin_pull_nxt = isp_busy ? '1 : '0;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      glob_r <= '0;
      pin_oe_r <= '0;
      pin_pull_r <= '0;
      pin_out_r <= '0;
      pin_fb_r <= '0;
      mc_fb_r <= '0;
      isp_r <= 1'b0;
    end else begin
      glob_r <= glob_nxt;
      pin_oe_r <= pin_oe_nxt;
      pin_pull_r <= pin_pull_nxt;
      pin_out_r <= mc_out;
      pin_fb_r <= pin_s_r;
      mc_fb_r <= mc_out;
      isp_r <= isp_busy;
    end
  end

  // ----------------------------------------------------------------
  // Mode sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_nxt = state_r;
    cnt_nxt = cnt_r;
    unique case (state_r)
      ST_USER: begin
        if (enter_ev) begin
          state_nxt = ST_ENTER;
          cnt_nxt = CNT_W'(SETTLE_CYC - 1);
        end
      end
      ST_ENTER: begin
        if (cnt_r == '0) begin
          state_nxt = ST_ISP;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
      ST_ISP: begin
        if (exit_ev) begin
          state_nxt = ST_EXIT;
          cnt_nxt = CNT_W'(SETTLE_CYC - 1);
        end
      end
      ST_EXIT: begin
        if (cnt_r == '0) begin
          state_nxt = ST_USER;
        end else begin
          cnt_nxt = cnt_r - 1'b1;
        end
      end
    endcase
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      state_r <= ST_USER;
      cnt_r <= '0;
    end else begin
      state_r <= state_nxt;
      cnt_r <= cnt_nxt;
    end
  end

  // ----------------------------------------------------------------
  // AXI4-Lite slave
  // ----------------------------------------------------------------
  always_comb begin
    aw_got_nxt = aw_got_r | (awvalid & awready_r);
    w_got_nxt = w_got_r | (wvalid & wready_r);
    awaddr_nxt = (awvalid & awready_r) ? awaddr : awaddr_r;
    wdata_nxt = (wvalid & wready_r) ? wdata : wdata_r;
    wstrb_nxt = (wvalid & wready_r) ? wstrb : wstrb_r;
    wa = awaddr_nxt;
    wd = wdata_nxt;
    ws = wstrb_nxt;
    wv = '0;
    ctrl_nxt = ctrl_r;
    psel_nxt = psel_r;
    gsrc_nxt = gsrc_r;
    bvalid_nxt = bvalid_r & ~bready;
    bresp_nxt = bresp_r;
    if (aw_got_nxt && w_got_nxt && !bvalid_r) begin
      aw_got_nxt = 1'b0;
      w_got_nxt = 1'b0;
      bvalid_nxt = 1'b1;
      bresp_nxt = RESP_OKAY;
      case ({wa[AW-1:2], 2'b00})
        A_CTRL: begin
          wv = merge({31'h00000000, ctrl_r}, wd, ws);
          ctrl_nxt = wv[CTRL_LARGE];
        end
        A_PSEL: begin
          wv = merge({8'h00, psel_r}, wd, ws);
          psel_nxt = wv[NPIN*PSEL_W-1:0];
        end
        A_GSRC: begin
          wv = merge({2'h0, gsrc_r}, wd, ws);
          gsrc_nxt = wv[NGLB*GSRC_W-1:0];
        end
        A_STAT: bresp_nxt = RESP_OKAY;
        default: bresp_nxt = RESP_SLVERR;
      endcase
    end
    awready_nxt = ~aw_got_nxt & ~bvalid_nxt;
    wready_nxt = ~w_got_nxt & ~bvalid_nxt;
    rvalid_nxt = rvalid_r & ~rready;
    rdata_nxt = rdata_r;
    rresp_nxt = rresp_r;
    if (arvalid && arready_r) begin
      rvalid_nxt = 1'b1;
      rresp_nxt = RESP_OKAY;
      case ({araddr[AW-1:2], 2'b00})
        A_CTRL: rdata_nxt = {31'h00000000, ctrl_r};
        A_PSEL: rdata_nxt = {8'h00, psel_r};
        A_GSRC: rdata_nxt = {2'h0, gsrc_r};
        A_STAT: rdata_nxt = {16'h0000, pin_fb_r, 5'h00, isp_busy, state_r};
        default: begin
          rdata_nxt = '0;
          rresp_nxt = RESP_SLVERR;
        end
      endcase
    end
    arready_nxt = ~rvalid_nxt;
  end

  always_ff @(posedge ref_clk) begin
    if (reset) begin
      ctrl_r <= CTRL_RST;
      psel_r <= PSEL_RST;
      gsrc_r <= GSRC_RST;
      aw_got_r <= 1'b0;
      w_got_r <= 1'b0;
      awaddr_r <= '0;
      wdata_r <= '0;
      wstrb_r <= '0;
      awready_r <= 1'b0;
      wready_r <= 1'b0;
      bvalid_r <= 1'b0;
      bresp_r <= RESP_OKAY;
      arready_r <= 1'b0;
      rvalid_r <= 1'b0;
      rdata_r <= '0;
      rresp_r <= RESP_OKAY;
    end else begin
      ctrl_r <= ctrl_nxt;
      psel_r <= psel_nxt;
      gsrc_r <= gsrc_nxt;
      aw_got_r <= aw_got_nxt;
      w_got_r <= w_got_nxt;
      awaddr_r <= awaddr_nxt;
      wdata_r <= wdata_nxt;
      wstrb_r <= wstrb_nxt;
      awready_r <= awready_nxt;
      wready_r <= wready_nxt;
      bvalid_r <= bvalid_nxt;
      bresp_r <= bresp_nxt;
      arready_r <= arready_nxt;
      rvalid_r <= rvalid_nxt;
      rdata_r <= rdata_nxt;
      rresp_r <= rresp_nxt;
    end
  end

  assign awready = awready_r;
  assign wready = wready_r;
  assign bvalid = bvalid_r;
  assign bresp = bresp_r;
  assign arready = arready_r;
  assign rvalid = rvalid_r;
  assign rdata = rdata_r;
  assign rresp = rresp_r;
  assign pin_out = pin_out_r;
  assign pin_oe = pin_oe_r;
  assign pin_pullup = pin_pull_r;
  assign pin_fb = pin_fb_r;
  assign mc_fb = mc_fb_r;
  assign isp_active = isp_r;

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge ref_clk);
  endclocking
  default disable iff (reset);

  for (genvar i = 0; i < NPIN; i++) begin : g_chk
    a_tie_low: assert property (
      $past(!isp_busy) && $past(psel_r[i*PSEL_W +: PSEL_W]) == SEL_LOW
      |-> !pin_oe_r[i])
      else $error("tied-low pin is driving");
    a_tie_high: assert property (
      $past(!isp_busy) && $past(psel_r[i*PSEL_W +: PSEL_W]) == SEL_HIGH
      |-> pin_oe_r[i])
      else $error("tied-high pin not driving");
    a_glob_follow: assert property (
      $past(!isp_busy) && $past(psel_r[i*PSEL_W +: PSEL_W]) == SEL_GLB0
      |-> pin_oe_r[i] == $past(glob_r[0]))
      else $error("pin enable does not follow global");
  end

  a_small_glob: assert property (
    !ctrl_r |=> glob_r == {4'h0, ~$past(oe_s_r)})
    else $error("small variant globals wrong");
  a_large_pin: assert property (
    ctrl_r && gsrc_r[4:3] == K_PIN
    |=> glob_r[0] == $past(pin_s_r[gsrc_r[2:0]]))
    else $error("global not taken from pin");
  a_fb_indep: assert property (
    isp_busy |=> mc_fb_r == $past(mc_out) && pin_fb_r == $past(pin_s_r))
    else $error("feedback paths disturbed");
  a_isp_hiz: assert property (
    isp_busy |=> pin_oe_r == '0 && pin_pull_r == '1)
    else $error("pins not released in programming");
  a_enter_take: assert property (
    state_r == ST_USER && enter_ev |=> state_r == ST_ENTER)
    else $error("enter command not taken");
  a_enter_load: assert property (
    $rose(state_r == ST_ENTER) |-> cnt_r == CNT_W'(SETTLE_CYC - 1))
    else $error("enter settle count wrong");
  a_enter_done: assert property (
    $rose(state_r == ST_ISP)
    |-> $past(state_r) == ST_ENTER && $past(cnt_r) == '0)
    else $error("programming mode entered early");
  a_exit_done: assert property (
    $fell(isp_busy) |-> $past(state_r) == ST_EXIT && $past(cnt_r) == '0)
    else $error("user mode resumed early");
  a_user_back: assert property (
    $fell(isp_busy) |=> pin_oe_r == $past(oe_user) && pin_pull_r == '0)
    else $error("user enables not restored");

  c_reach_isp: cover property ($rose(state_r == ST_ISP));
  c_back_user: cover property ($fell(isp_busy));
  c_write_done: cover property (bvalid_r && bready);

endmodule : ieis_top

`default_nettype wire

/* tb/ieis_prog_model.sv */
// Behavioural programmer on the serial test port.
// Assumes the device samples tms and tdi on tck rise, tdo after it.
`default_nettype none

module ieis_prog_model import ieis_pkg::*; (
  output logic tck,
  output logic tms,
  output logic tdi,
  input wire logic tdo
);
  timeunit 1ns;
  timeprecision 1ns;

  initial begin
    tck = 1'b0;
    tms = 1'b0;
    tdi = 1'b0;
  end

  // ----------------------------------------------------------------
  // Link cycles
  // ----------------------------------------------------------------
  // One 64 ns cycle; tck rests low so it stands still between frames
  task automatic pulse(output logic q);
    #32 q = tdo;
    tck = 1'b1;
    #32 tck = 1'b0;
  endtask : pulse

  // Reload, shift a command LSB first while catching the identifier
  task automatic send(input logic [IR_W-1:0] c,
                      output logic [IR_W-1:0] id);
    logic q;
    tms = 1'b0;
    pulse(q);
    tms = 1'b1;
    for (int i = 0; i < IR_W; i++) begin
      tdi = c[i];
      pulse(id[i]);
    end
    tms = 1'b0;
    tdi = ~tdi;
    pulse(q);
  endtask : send

  // Stage instructions; the device ignores any code but enter and exit
  localparam logic [IR_W-1:0] OP_ERASE = 8'h11;
  localparam logic [IR_W-1:0] OP_PROG = 8'h22;
  localparam logic [IR_W-1:0] OP_READ = 8'h33;

  // Instruction, then address, then the pulse with tck at rest
  task automatic stage(input logic [1:0] k, input logic [IR_W-1:0] a,
                       input int t_ns, output logic [2*IR_W-1:0] ids);
    logic [IR_W-1:0] c;
    c = (k == 2'h0) ? OP_ERASE : (k == 2'h1) ? OP_PROG : OP_READ;
    send(c, ids[2*IR_W-1:IR_W]);
    send(a, ids[IR_W-1:0]);
    // Stage time is this pulse plus the shift cycles above
    #(t_ns);
  endtask : stage
endmodule : ieis_prog_model

`default_nettype wire

/* tb/ieis_top_tb.sv */
// Self-checking bench for the enable and programming sequencer.
// Assumes the design package and a short settle parameter of 20.
`default_nettype none

module ieis_top_tb;
  import ieis_pkg::*;
  timeunit 1ns;
  timeprecision 100ps;

  localparam int SC = 20;
  localparam int PULSE_NS = 500;
  logic ref_clk, reset, awvalid, awready, wvalid, wready, bvalid, bready;
  logic arvalid, arready, rvalid, rready, tck, tms, tdi, tdo, isp_active;
  logic output_enable_pin_a_n, output_enable_pin_b_n;
  logic [AW-1:0] awaddr, araddr;
  logic [31:0] wdata, rdata, d;
  logic [3:0] wstrb;
  logic [1:0] bresp, rresp;
  logic [NPIN-1:0] pin_in, mc_out, pin_out, pin_oe, pin_pullup, pin_fb, mc_fb;
  logic [IR_W-1:0] id;
  logic [2*IR_W-1:0] ids;
  logic [31:0] last_ps, last_gs;
  logic q;
  integer seed = 32'h88CC;
  int errors = 0;
  int cmp_count = 0;
  int cyc = 0;
  int n;

  ieis_top #(.SETTLE_CYC(SC)) i_dut (.ref_clk, .reset, .awvalid, .awready,
    .awaddr, .wvalid, .wready, .wdata, .wstrb, .bvalid, .bready, .bresp,
    .arvalid, .arready, .araddr, .rvalid, .rready, .rdata, .rresp,
    .output_enable_pin_a_n, .output_enable_pin_b_n, .pin_in, .mc_out, .tck,
    .tms, .tdi, .tdo, .pin_out, .pin_oe, .pin_pullup, .pin_fb, .mc_fb,
    .isp_active);

  ieis_prog_model i_prog (.tck, .tms, .tdi, .tdo);

  // ----------------------------------------------------------------
  // Checking and closing
  // ----------------------------------------------------------------
  task automatic chk(input string nm, input logic [31:0] s,
                     input logic [31:0] e);
    cmp_count++;
    if (s !== e) begin
      errors++;
      $display("ERROR %s expected %h seen %h", nm, e, s);
    end
  endtask : chk

  task automatic close_out;
    if (errors == 0 && cmp_count > 0) begin
      $display("Run complete: PASS");
    end else begin
      $display("Run complete: FAIL");
    end
    $finish;
  endtask : close_out

  initial begin
    ref_clk = 1'b0;
    forever #12.5 ref_clk = ~ref_clk;
  end

  // Generous ceiling; the whole run needs about a thousand cycles
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 20000) begin
      errors++;
      close_out();
    end
  end

  // ----------------------------------------------------------------
  // Bus master
  // ----------------------------------------------------------------
  task automatic wr(input logic [AW-1:0] a, input logic [31:0] dv,
                    input logic [1:0] er);
    @(posedge ref_clk);
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    awaddr <= a;
    wdata <= dv;
    bready <= 1'b1;
    fork
      begin
        do @(posedge ref_clk); while (!awready);
        awvalid <= 1'b0;
      end
      begin
        do @(posedge ref_clk); while (!wready);
        wvalid <= 1'b0;
      end
    join
    do @(posedge ref_clk); while (!bvalid);
    bready <= 1'b0;
    chk("bresp", bresp, er);
  endtask : wr

  task automatic rd(input logic [AW-1:0] a, input logic [1:0] er,
                    output logic [31:0] dv);
    @(posedge ref_clk);
    arvalid <= 1'b1;
    araddr <= a;
    rready <= 1'b1;
    do @(posedge ref_clk); while (!arready);
    arvalid <= 1'b0;
    do @(posedge ref_clk); while (!rvalid);
    dv = rdata;
    rready <= 1'b0;
    chk("rresp", rresp, er);
  endtask : rd

  // ----------------------------------------------------------------
  // Expectations
  // ----------------------------------------------------------------
  function automatic logic [NPIN-1:0] exp_oe(input logic lg,
      input logic [31:0] ps, input logic [31:0] gs);
    logic [NGLB-1:0] g;
    logic [4:0] f;
    logic [2:0] s;
    logic [NPIN-1:0] o;
    g = {4'h0, ~output_enable_pin_b_n, ~output_enable_pin_a_n};
    for (int k = 0; k < NGLB; k++) begin
      f = gs[5*k +: 5];
      if (lg) begin
        case (f[4:3])
          K_ENA: g[k] = (f[1] ? ~output_enable_pin_b_n
                               : ~output_enable_pin_a_n) ^ f[0];
          K_PIN: g[k] = pin_in[f[2:0]];
          K_MC: g[k] = mc_out[f[2:0]];
          default: g[k] = 1'b0;
        endcase
      end
    end
    for (int i = 0; i < NPIN; i++) begin
      s = ps[3*i +: 3];
      o[i] = (s == SEL_LOW) ? 1'b0 : (s == SEL_HIGH) ? 1'b1 : g[s - SEL_GLB0];
    end
    return o;
  endfunction : exp_oe

  // Given select map, random source map, with random pin and macrocell levels
  task automatic mix(input logic lg, input logic [31:0] ps);
    logic [31:0] gs;
    gs = $random(seed);
    last_ps = ps;
    last_gs = gs;
    wr(A_PSEL, ps, RESP_OKAY);
    wr(A_GSRC, gs, RESP_OKAY);
    output_enable_pin_a_n <= $random(seed);
    output_enable_pin_b_n <= $random(seed);
    pin_in <= $random(seed);
    mc_out <= $random(seed);
    repeat (8) @(posedge ref_clk);
    chk("pin_oe", pin_oe, exp_oe(lg, ps, gs));
    chk("pin_fb", pin_fb, pin_in);
    chk("mc_fb", mc_fb, mc_out);
    chk("pin_out", pin_out, mc_out);
  endtask : mix

  // ----------------------------------------------------------------
  // Main sequence
  // ----------------------------------------------------------------
  initial begin
    reset = 1'b1;
    {awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata} = '0;
    wstrb = 4'hF;
    {output_enable_pin_a_n, output_enable_pin_b_n} = 2'h3;
    pin_in = '0;
    mc_out = '0;
    // The link side needs tck edges while reset is held
    fork
      repeat (3) i_prog.pulse(q);
      repeat (8) @(posedge ref_clk);
    join
    @(posedge ref_clk);
    reset <= 1'b0;
    // Link reset only clears while tck runs, so idle it after release
    repeat (2) i_prog.pulse(q);
    rd(A_CTRL, RESP_OKAY, d);
    chk("ctrl", d, 32'h0);
    rd(A_PSEL, RESP_OKAY, d);
    chk("psel", d, 32'h0);
    rd(A_GSRC, RESP_OKAY, d);
    chk("gsrc", d, 32'h0);
    rd(5'h10, RESP_SLVERR, d);
    chk("unmapped", d, 32'h0);
    wr(5'h14, 32'hFFFFFFFF, RESP_SLVERR);
    wr(A_STAT, 32'hFFFFFFFF, RESP_OKAY);
    mix(1'b0, 32'h00249249);
    mix(1'b0, 32'h0);
    repeat (12) mix(1'b0, $random(seed));
    wr(A_CTRL, 32'h1, RESP_OKAY);
    repeat (24) mix(1'b1, $random(seed));
    rd(A_STAT, RESP_OKAY, d);
    chk("stat_fb", d[15:8], pin_fb);
    i_prog.send(CMD_ENTER, id);
    chk("id", id, SILICON_ID);
    n = 0;
    while (isp_active !== 1'b1 && n < 50) begin
      @(posedge ref_clk);
      n++;
    end
    repeat (2) @(posedge ref_clk);
    chk("isp_oe", pin_oe, 32'h0);
    chk("isp_pull", pin_pullup, 32'hFF);
    rd(A_STAT, RESP_OKAY, d);
    chk("state", d[1:0], ST_ENTER);
    output_enable_pin_a_n <= 1'b0;
    repeat (SC + 5) @(posedge ref_clk);
    rd(A_STAT, RESP_OKAY, d);
    chk("state", d[1:0], ST_ISP);
    chk("isp_oe", pin_oe, 32'h0);
    // Erase, two program steps, two verify steps while in programming
    for (int k = 0; k < 5; k++) begin
      i_prog.stage(k == 0 ? 2'h0 : k < 3 ? 2'h1 : 2'h2, 8'(k), PULSE_NS, ids);
      chk("stage_id", ids, {2{SILICON_ID}});
    end
    i_prog.send(CMD_EXIT, id);
    chk("id", id, SILICON_ID);
    n = 0;
    while (isp_active === 1'b1 && n < 200) begin
      @(posedge ref_clk);
      n++;
    end
    chk("exit_hold", n >= SC, 32'h1);
    repeat (2) @(posedge ref_clk);
    chk("pin_oe", pin_oe, exp_oe(1'b1, last_ps, last_gs));
    chk("pullup", pin_pullup, 32'h0);
    rd(A_STAT, RESP_OKAY, d);
    chk("state", d[1:0], ST_USER);
    mix(1'b1, $random(seed));
    close_out();
  end
endmodule : ieis_top_tb

`default_nettype wire
